// >>> epi_pin_irq.sv
// module: external pin and pin-change interrupt unit with apb registers
//
// Operation
// R01: pins request even when driven as outputs
// R02: low level requests while pin stays low
// R03: any unmasked change on 15..8 raises high
// R04: any unmasked change on 7..0 raises low
// R05: mask registers choose contributing pin-change inputs
// R06: pin one/zero edges need running io clock
// R07: levels, pin two, pin-change detected clocklessly, wake
// R08: power-down level wake needs two watchdog samples
// R09: level gone before start-up: wake, no interrupt
// R10: pin one sense at bits 3:2
// R11: pin zero sense at bits 1:0
// R12: sample pin before edge detect
// R13: source holds low level until instruction ends
// R14: take only with global and own enable
// R15: pin two edge select at bit 0
// R16: software disables pin two before changing sense
// R17: enable bits 7..3, bit 2 reads zero
// R18: each source has its own request vector
// R19: flag sets on trigger, clears on service/write-one
// R20: level-mode flag reads as zero
// R21: mask bit enables its pin under group enable
// R22: two-stage synchroniser then compare samples
// R23: request is flag and enable and global
module epi_pin_irq (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // pins
   input wire logic i_ext_irq_pin_zero,
   input wire logic i_ext_irq_pin_one,
   input wire logic i_ext_irq_pin_two,
   input wire logic [15:0] i_pin_change_inputs,
   // core side
   input wire logic i_global_irq_enable,
   input wire logic i_io_clk_run,
   input wire logic i_wdt_tick,
   input wire logic i_power_down,
   input wire logic i_startup_done,
   input wire logic [4:0] i_vector_ack,
   output logic [4:0] o_irq_req,
   output logic o_wake
);

   // bundled bus request
   epi_pkg::epi_apb_req_type apb_req;
   logic wr_fire; // write takes effect this edge
   logic rd_load; // read data captured this edge
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   // software registers
   logic [3:0] sense_low_ff; // both two-bit sense fields
   logic sense_two_ff; // edge select of pin two
   epi_pkg::epi_src_type enable_ff; // per-source enables
   epi_pkg::epi_src_type flag_ff; // sticky source flags
   epi_pkg::epi_src_type nxt_flag;
   logic [7:0] mask_low_ff;
   logic [7:0] mask_high_ff;

   // pin sampling
   logic [epi_pkg::NUM_PINS-1:0] pin_vec;
   logic [epi_pkg::NUM_PINS-1:0] pin_en;
   logic [epi_pkg::NUM_PINS-1:0] pin_level;
   logic [epi_pkg::NUM_PINS-1:0] pin_rise;
   logic [epi_pkg::NUM_PINS-1:0] pin_fall;

   // decoded sense
   epi_pkg::epi_sense_type sense_one;
   epi_pkg::epi_sense_type sense_zero;
   logic level_mode_one;
   logic level_mode_zero;
   logic level_low_one; // enabled low level on pin one
   logic level_low_zero;

   // events and requests
   epi_pkg::epi_src_type set_ev;
   epi_pkg::epi_src_type clr_ev;
   epi_pkg::epi_src_type nxt_req;
   epi_pkg::epi_src_type req_ff;
   logic nxt_wake;
   logic wake_ff;

   // level wake sequencer
   epi_pkg::epi_lw_state_type lw_state_ff;
   epi_pkg::epi_lw_state_type nxt_lw_state;

   // true for every mapped register offset
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == epi_pkg::OFS_SENSE_LOW) || (a == epi_pkg::OFS_SENSE_EXTENDED) ||
                (a == epi_pkg::OFS_ENABLE_CONTROL) || (a == epi_pkg::OFS_FLAG) ||
                (a == epi_pkg::OFS_MASK_LOW) || (a == epi_pkg::OFS_MASK_HIGH) ||
                (a == epi_pkg::OFS_PIN_STATUS);
   endfunction : addr_ok

   // edge hit for a two-bit sense field; low level never sets the flag
   function automatic logic sense_hit(input epi_pkg::epi_sense_type s,
                                      input logic rise, input logic fall);
      unique case (s)
         epi_pkg::SENSE_LOW_LEVEL: sense_hit = 1'b0;
         epi_pkg::SENSE_ANY_CHANGE: sense_hit = rise | fall;
         epi_pkg::SENSE_FALLING: sense_hit = fall;
         epi_pkg::SENSE_RISING: sense_hit = rise;
      endcase
   endfunction : sense_hit

   // bus bundle
   assign apb_req = '{sel: i_psel, enable: i_penable, write: i_pwrite,
                      addr: i_paddr, wdata: i_pwdata};

   // one wait state: ready is set at the end of the first access cycle, completes in the second
   assign wr_fire = apb_req.sel & apb_req.enable & pready_ff & apb_req.write &
                    addr_ok(apb_req.addr);
   assign rd_load = apb_req.sel & apb_req.enable & ~pready_ff;

   // pins are sampled as levels whatever their direction, so port writes can fire them
   assign pin_vec = {i_ext_irq_pin_two, i_ext_irq_pin_one, i_ext_irq_pin_zero,
                     i_pin_change_inputs}; // see R01

   // edge detect on pins one/zero only while the io clock runs; others always
   always_comb begin
      pin_en = '1;
      pin_en[epi_pkg::PIN_ONE_IDX] = i_io_clk_run; // see R06
      pin_en[epi_pkg::PIN_ZERO_IDX] = i_io_clk_run; // see R06
   end

   // shared synchroniser and edge detector for all 19 inputs
   epi_pin_sampler #(
      .WIDTH(epi_pkg::NUM_PINS)
   ) u_sampler (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_pins(pin_vec),
      .i_sample_en(pin_en),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   // sense field decode
   assign sense_one = epi_pkg::epi_sense_type'(sense_low_ff[epi_pkg::SENSE_ONE_POS +: 2]); // see R10
   assign sense_zero = epi_pkg::epi_sense_type'(sense_low_ff[epi_pkg::SENSE_ZERO_POS +: 2]); // see R11
   assign level_mode_one = (sense_one == epi_pkg::SENSE_LOW_LEVEL);
   assign level_mode_zero = (sense_zero == epi_pkg::SENSE_LOW_LEVEL);
   // low level is seen without the io clock, so it can wake from any sleep
   assign level_low_one = level_mode_one & enable_ff.pin_one &
                          ~pin_level[epi_pkg::PIN_ONE_IDX]; // see R07
   assign level_low_zero = level_mode_zero & enable_ff.pin_zero &
                           ~pin_level[epi_pkg::PIN_ZERO_IDX]; // see R07

   // trigger events per source
   always_comb begin
      set_ev.pin_one = sense_hit(sense_one, pin_rise[epi_pkg::PIN_ONE_IDX],
                                 pin_fall[epi_pkg::PIN_ONE_IDX]); // see R10
      set_ev.pin_zero = sense_hit(sense_zero, pin_rise[epi_pkg::PIN_ZERO_IDX],
                                  pin_fall[epi_pkg::PIN_ZERO_IDX]); // see R11
      // pin two: 0 falling, 1 rising, detected whether or not the io clock runs
      set_ev.pin_two = sense_two_ff ? pin_rise[epi_pkg::PIN_TWO_IDX] :
                                      pin_fall[epi_pkg::PIN_TWO_IDX]; // see R15
      set_ev.pc_high = |(mask_high_ff & (pin_rise[15:8] | pin_fall[15:8])); // see R03
      set_ev.pc_low = |(mask_low_ff & (pin_rise[7:0] | pin_fall[7:0])); // see R04
   end

   // clears: write one to the flag, or the vector being serviced
   always_comb begin
      clr_ev = epi_pkg::epi_src_type'(i_vector_ack); // see R19
      if (wr_fire && (apb_req.addr == epi_pkg::OFS_FLAG)) begin
         clr_ev = clr_ev | epi_pkg::epi_src_type'(
                  apb_req.wdata[epi_pkg::SRC_LSB +: epi_pkg::NUM_SRC]); // see R19
      end
   end

   // flag next value; set beats a clear landing in the same cycle
   always_comb begin
      nxt_flag = set_ev | (flag_ff & ~clr_ev); // see R19
      if (level_mode_one) begin
         nxt_flag.pin_one = 1'b0; // see R20
      end
      if (level_mode_zero) begin
         nxt_flag.pin_zero = 1'b0; // see R20
      end
   end

   // sticky flags
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // per-vector requests, one line each so each has its own vector
   always_comb begin
      nxt_req = nxt_flag & enable_ff &
                {epi_pkg::NUM_SRC{i_global_irq_enable}}; // see R23
      // level mode: request follows the pin while it stays low
      if (level_mode_one) begin
         nxt_req.pin_one = level_low_one & i_global_irq_enable; // see R02
      end
      if (level_mode_zero) begin
         nxt_req.pin_zero = level_low_zero & i_global_irq_enable; // see R14
      end
   end

   // request register; each bit drives a separate vector
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_ff <= '0;
      end else begin
         req_ff <= nxt_req; // see R18
      end
   end

   // power-down level wake: two watchdog samples, then hold until start-up ends
   always_comb begin
      nxt_lw_state = lw_state_ff;
      unique case (lw_state_ff)
         epi_pkg::LW_IDLE: begin
            if (i_power_down && i_wdt_tick && (level_low_one || level_low_zero)) begin
               nxt_lw_state = epi_pkg::LW_ONE_SAMPLE; // see R08
            end
         end
         epi_pkg::LW_ONE_SAMPLE: begin
            if (!i_power_down) begin
               nxt_lw_state = epi_pkg::LW_IDLE; // woken some other way
            end else if (i_wdt_tick) begin
               // second sample must still see the level
               nxt_lw_state = (level_low_one || level_low_zero) ? epi_pkg::LW_WAKING :
                                                                  epi_pkg::LW_IDLE; // see R08
            end
         end
         epi_pkg::LW_WAKING: begin
            if (i_startup_done) begin
               nxt_lw_state = epi_pkg::LW_IDLE; // see R09
            end
         end
         default: begin
            nxt_lw_state = epi_pkg::LW_IDLE; // illegal one-hot code
         end
      endcase
   end

   // level wake state register
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lw_state_ff <= epi_pkg::LW_IDLE;
      end else begin
         lw_state_ff <= nxt_lw_state;
      end
   end

   // wake: edge/pin-change requests always; level only via the sampled sequence
   // in power-down, which filters noise. the interrupt itself still needs the
   // live level at start-up end, so a vanished level wakes without interrupting
   always_comb begin
      nxt_wake = nxt_req.pin_two | nxt_req.pc_high | nxt_req.pc_low |
                 (lw_state_ff == epi_pkg::LW_WAKING); // see R09
      if (!level_mode_one || !i_power_down) begin
         nxt_wake = nxt_wake | nxt_req.pin_one; // see R07
      end
      if (!level_mode_zero || !i_power_down) begin
         nxt_wake = nxt_wake | nxt_req.pin_zero; // see R07
      end
   end

   // wake register
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   // sense registers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sense_low_ff <= epi_pkg::RST_BYTE[3:0];
         sense_two_ff <= epi_pkg::RST_BYTE[0];
      end else if (wr_fire) begin
         if (apb_req.addr == epi_pkg::OFS_SENSE_LOW) begin
            sense_low_ff <= apb_req.wdata[3:0]; // see R10
         end
         // changing this may raise a spurious flag; software guards it
         if (apb_req.addr == epi_pkg::OFS_SENSE_EXTENDED) begin
            sense_two_ff <= apb_req.wdata[epi_pkg::SENSE_TWO_POS]; // see R16
         end
      end
   end

   // enable register, bits 7:3; bit 2 and below are not stored
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enable_ff <= epi_pkg::epi_src_type'(epi_pkg::RST_BYTE[7:3]);
      end else if (wr_fire && (apb_req.addr == epi_pkg::OFS_ENABLE_CONTROL)) begin
         enable_ff <= epi_pkg::epi_src_type'(
                      apb_req.wdata[epi_pkg::SRC_LSB +: epi_pkg::NUM_SRC]); // see R17
      end
   end

   // pin-change masks; group enable gates the request, not the mask
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_low_ff <= epi_pkg::RST_BYTE;
         mask_high_ff <= epi_pkg::RST_BYTE;
      end else if (wr_fire) begin
         if (apb_req.addr == epi_pkg::OFS_MASK_LOW) begin
            mask_low_ff <= apb_req.wdata[7:0]; // see R05
         end
         if (apb_req.addr == epi_pkg::OFS_MASK_HIGH) begin
            mask_high_ff <= apb_req.wdata[7:0]; // see R21
         end
      end
   end

   // read mux; unused bits read zero
   always_comb begin
      nxt_prdata = epi_pkg::RST_WORD;
      unique case (apb_req.addr)
         epi_pkg::OFS_SENSE_LOW: nxt_prdata[3:0] = sense_low_ff;
         epi_pkg::OFS_SENSE_EXTENDED: nxt_prdata[epi_pkg::SENSE_TWO_POS] = sense_two_ff;
         epi_pkg::OFS_ENABLE_CONTROL: begin
            nxt_prdata[epi_pkg::SRC_LSB +: epi_pkg::NUM_SRC] = enable_ff; // see R17
         end
         epi_pkg::OFS_FLAG: nxt_prdata[epi_pkg::SRC_LSB +: epi_pkg::NUM_SRC] = flag_ff;
         epi_pkg::OFS_MASK_LOW: nxt_prdata[7:0] = mask_low_ff;
         epi_pkg::OFS_MASK_HIGH: nxt_prdata[7:0] = mask_high_ff;
         epi_pkg::OFS_PIN_STATUS: begin
            nxt_prdata[epi_pkg::NUM_PINS-1:0] = pin_level;
            nxt_prdata[epi_pkg::STATUS_STATE_POS +: 3] = lw_state_ff;
         end
         default: nxt_prdata = epi_pkg::RST_WORD; // unmapped
      endcase
   end

   // apb handshake: one wait state, error on unmapped address
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= rd_load;
         pslverr_ff <= rd_load & ~addr_ok(apb_req.addr);
      end
   end

   // read data captured with ready so it stands through completion
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_ff <= epi_pkg::RST_WORD;
      end else if (rd_load) begin
         prdata_ff <= apb_req.write ? epi_pkg::RST_WORD : nxt_prdata;
      end
   end

   // outputs straight from flip-flops
   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_irq_req = req_ff;
   assign o_wake = wake_ff;

endmodule : epi_pin_irq

// >>> epi_pkg.sv
// package: register map, field layout, types and constants of the pin interrupt unit
package epi_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_SENSE_LOW = 8'h00; // ext_irq_sense_low
   localparam logic [7:0] OFS_SENSE_EXTENDED = 8'h04; // ext_irq_sense_extended
   localparam logic [7:0] OFS_ENABLE_CONTROL = 8'h08; // ext_irq_enable_control
   localparam logic [7:0] OFS_FLAG = 8'h0c; // ext_irq_flag_register
   localparam logic [7:0] OFS_MASK_LOW = 8'h10; // pin_change_mask_low
   localparam logic [7:0] OFS_MASK_HIGH = 8'h14; // pin_change_mask_high
   localparam logic [7:0] OFS_PIN_STATUS = 8'h18; // synced pin levels and wake state

   // field positions
   localparam int SENSE_ONE_POS = 2; // sense_one_bit_hi/lo at bits 3:2
   localparam int SENSE_ZERO_POS = 0; // sense_zero_bit_hi/lo at bits 1:0
   localparam int SENSE_TWO_POS = 0; // sense_two_edge_select at bit 0
   localparam int SRC_LSB = 3; // five source bits sit at 7:3 in enable and flag
   localparam int STATUS_STATE_POS = 19; // wake state bits above the 19 pin levels

   // widths
   localparam int NUM_SRC = 5;
   localparam int NUM_PC = 16;
   localparam int NUM_PINS = 19;
   localparam int PIN_TWO_IDX = 18;
   localparam int PIN_ONE_IDX = 17;
   localparam int PIN_ZERO_IDX = 16;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // timing
   localparam int CLK_PERIOD_NS = 5; // i_mclk at 200 mhz
   localparam int MIN_PULSE_NS = 50; // shortest pulse the edge-only pin must catch
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] WDT_SAMPLES = 2'h2; // watchdog ticks a wake level must last

   // sense control encodings for the two level-capable pins
   typedef enum logic [1:0] {
      SENSE_LOW_LEVEL = 2'b00,
      SENSE_ANY_CHANGE = 2'b01,
      SENSE_FALLING = 2'b10,
      SENSE_RISING = 2'b11
   } epi_sense_type;

   // one bit per source, msb first in the same order as register bits 7:3
   typedef struct packed {
      logic pin_one;
      logic pin_zero;
      logic pin_two;
      logic pc_high;
      logic pc_low;
   } epi_src_type;

   // apb request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } epi_apb_req_type;

   // power-down level wake sequencer
   typedef enum logic [2:0] {
      LW_IDLE = 3'b001,
      LW_ONE_SAMPLE = 3'b010,
      LW_WAKING = 3'b100
   } epi_lw_state_type;

endpackage : epi_pkg

// >>> epi_pin_sampler.sv
// module: two-stage pin synchroniser with gated edge detection
module epi_pin_sampler #(
   parameter int WIDTH = 19
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_pins, // raw pin levels, direction ignored
   input wire logic [WIDTH-1:0] i_sample_en, // per-pin clock-present gate
   output logic [WIDTH-1:0] o_level, // synchronised level
   output logic [WIDTH-1:0] o_rise, // one-cycle rising event
   output logic [WIDTH-1:0] o_fall // one-cycle falling event
);

   logic [WIDTH-1:0] meta_ff; // first stage, read only by sync_ff
   logic [WIDTH-1:0] sync_ff; // second stage
   logic [WIDTH-1:0] prev_ff; // last sample taken while enabled

   // synchroniser chain
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= i_pins;
         sync_ff <= meta_ff; // see R22
      end
   end

   // previous sample freezes while the pin's clock is gated off
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= (i_sample_en & sync_ff) | (~i_sample_en & prev_ff);
      end
   end

   // compare current and previous sample; any pulse over one period shows here while the pin's sample enable is set
   assign o_level = sync_ff;
   assign o_rise = i_sample_en & sync_ff & ~prev_ff; // see R22
   assign o_fall = i_sample_en & ~sync_ff & prev_ff; // see R12

endmodule : epi_pin_sampler

// >>> epi_pin_irq_asserts.sv
// checker: port-level assertions on the pin interrupt unit
module epi_pin_irq_asserts (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [15:0] i_pin_change_inputs,
   input wire logic i_global_irq_enable,
   input wire logic [4:0] i_vector_ack,
   input wire logic [4:0] o_irq_req,
   input wire logic o_wake
);
   timeunit 1ns;
   timeprecision 100ps;
   // one clock domain, so one clocking and one disable
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   // setup cycle then first access cycle
   sequence s_apb_start;
      i_psel && !i_penable ##1 i_psel && i_penable;
   endsequence
   // inputs quiet long enough that no change event is still in flight
   sequence s_quiet_ack;
      $stable(i_pin_change_inputs)[*4] ##0 i_vector_ack[1];
   endsequence
   AST_APB_ONE_WAIT: assert property (s_apb_start |-> !o_pready ##1 o_pready)
      else $error("pready not in second access cycle");
   AST_READY_PULSE: assert property (o_pready |=> !o_pready)
      else $error("pready held too long");
   AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   AST_ERR_UNMAPPED: assert property (o_pready && $past(i_paddr) > 8'h18 |-> o_pslverr)
      else $error("unmapped access not refused");
   AST_OK_MAPPED: assert property (o_pready && $past(i_paddr) <= 8'h18
         && $past(i_paddr[1:0]) == 2'h0 |-> !o_pslverr)
      else $error("mapped access refused");
   AST_ERR_READ_ZERO: assert property (o_pslverr && !$past(i_pwrite) |-> o_prdata == 32'h0)
      else $error("refused read returned data");
   AST_RESET_QUIET: assert property ($rose(i_rst_n) |-> o_irq_req == 5'h00 && !o_wake)
      else $error("outputs active after reset");
   AST_GLOBAL_GATE: assert property (!i_global_irq_enable |=> o_irq_req == 5'h00)
      else $error("request without global enable");
   AST_ACK_CLEARS: assert property (s_quiet_ack |=> !o_irq_req[1])
      else $error("serviced request still raised");
endmodule : epi_pin_irq_asserts

// >>> epi_core_model.sv
// model: core side that services pending vectors after a delay
module epi_core_model #(
   parameter int ACK_DELAY = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ack_en, // servicing allowed
   input wire logic [4:0] i_irq_req,
   output logic [4:0] o_vector_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   int wait_ff; // cycles a request has been pending
   // lowest pending vector serviced alone, one pulse, then a gap
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_ff <= 0;
         o_vector_ack <= 5'h00;
      end else begin
         o_vector_ack <= 5'h00;
         if (!i_ack_en || i_irq_req == 5'h00 || o_vector_ack != 5'h00) begin
            wait_ff <= 0;
         end else if (wait_ff < ACK_DELAY) begin
            wait_ff <= wait_ff + 1;
         end else begin
            wait_ff <= 0;
            o_vector_ack <= i_irq_req & ~(i_irq_req - 5'h01);
         end
      end
   end
endmodule : epi_core_model

// >>> tb_top.sv
// testbench: register, pin-change, sense, clock-stop and wake scenarios
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, o_wake, err;
   logic [2:0] pins = 3'b111; // two, one, zero
   logic [15:0] i_pin_change_inputs = 16'h0000;
   logic i_global_irq_enable = 1'b0, i_io_clk_run = 1'b1, i_wdt_tick = 1'b0;
   logic i_power_down = 1'b0, i_startup_done = 1'b0, ack_en = 1'b0;
   logic [4:0] i_vector_ack, o_irq_req;
   int n_errors = 0;
   int checks_done = 0;
   always #2.5 i_mclk = ~i_mclk;
   epi_pin_irq uut (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_ext_irq_pin_zero(pins[0]),
      .i_ext_irq_pin_one(pins[1]), .i_ext_irq_pin_two(pins[2]), .i_pin_change_inputs,
      .i_global_irq_enable, .i_io_clk_run, .i_wdt_tick, .i_power_down, .i_startup_done,
      .i_vector_ack, .o_irq_req, .o_wake);
   // core partner services vectors only when allowed
   epi_core_model u_core (.i_mclk, .i_rst_n, .i_ack_en(ack_en), .i_irq_req(o_irq_req),
      .o_vector_ack(i_vector_ack));
   task automatic tally_and_finish(input bit hung);
      if (hung) n_errors++;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   // apb transfer: hold request until pready is seen at an edge
   task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
      int k;
      i_psel <= 1'b1;
      i_pwrite <= wr_n;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (o_pready !== 1'b1 && k < 20);
      if (k >= 20) tally_and_finish(1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdx
   // reset values, access kinds and the unmapped hole
   task automatic t_regs();
      for (int a = 0; a < 24; a += 4) begin
         rdx(8'(a), 32'h0);
      end
      rdx(8'h18, 32'h000f_0000); // pins high, wake idle
      wr(8'h08, 32'hff);
      rdx(8'h08, 32'hf8);
      wr(8'h10, 32'hff);
      rdx(8'h10, 32'hff);
      wr(8'h08, 32'h0);
      wr(8'h10, 32'h0);
      apb(1'b1, 8'h1c, 32'hff);
      chk(err, 1'b1); // refused write
      rdx(8'h1c, 32'h0);
      chk(err, 1'b1); // refused read
   endtask : t_regs
   // one group: masked input silent, unmasked one requests, then cleared
   task automatic t_pc(input int g);
      wr(8'h08, 32'h08 << g);
      wr(8'(16 + 4 * g), 32'h02);
      i_pin_change_inputs[8*g] <= 1'b1;
      cyc(6);
      rdx(8'h0c, 32'h0);
      i_pin_change_inputs[8*g+1] <= 1'b1;
      cyc(6);
      chk(o_irq_req, 32'h0);
      i_global_irq_enable <= 1'b1;
      cyc(2);
      chk(o_irq_req, 32'h1 << g);
      ack_en <= 1'b1;
      cyc(12);
      chk(o_irq_req, 32'h0);
      ack_en <= 1'b0;
      i_pin_change_inputs[8*g+1] <= 1'b0;
      cyc(6);
      chk(o_irq_req, 32'h1 << g);
      wr(8'h0c, 32'hf8);
      chk(o_irq_req, 32'h0);
      i_global_irq_enable <= 1'b0;
      wr(8'h08, 32'h0);
   endtask : t_pc
   // one sense code on one dedicated pin: fall, clear, rise
   task automatic t_sense(input int s, input logic [1:0] code);
      int eb;
      eb = (s == 0) ? 6 : (s == 1) ? 7 : 5;
      if (s == 2) wr(8'h04, 32'(code[0]));
      else wr(8'h00, 32'(code) << (2 * s));
      wr(8'h0c, 32'hf8);
      wr(8'h08, 32'h1 << eb);
      pins[s] <= 1'b0; // held low for many cycles
      cyc(6);
      chk(o_irq_req, 32'(code != 2'b11) << (eb - 3));
      rdx(8'h0c, 32'(^code) << eb);
      wr(8'h0c, 32'hf8);
      chk(o_irq_req, 32'(code == 2'b00) << (eb - 3));
      pins[s] <= 1'b1;
      cyc(6);
      chk(o_irq_req, 32'(code[0]) << (eb - 3));
      wr(8'h08, 32'h0);
   endtask : t_sense
   // io clock stopped: pin zero edges lost, pin two still caught
   task automatic t_ioclk();
      wr(8'h00, 32'h03);
      wr(8'h04, 32'h01);
      wr(8'h0c, 32'hf8);
      wr(8'h08, 32'h60);
      i_io_clk_run <= 1'b0;
      pins <= 3'b010;
      cyc(4);
      pins <= 3'b111;
      cyc(8);
      chk(o_irq_req, 32'h04);
      i_io_clk_run <= 1'b1;
      pins[0] <= 1'b0;
      cyc(2);
      pins[0] <= 1'b1;
      cyc(6);
      chk(o_irq_req, 32'h0c);
      wr(8'h08, 32'h0);
   endtask : t_ioclk
   // power-down level wake, level released or held through start-up
   task automatic t_wake();
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'hf8);
      wr(8'h08, 32'h40);
      for (int h = 0; h < 2; h++) begin
         i_startup_done <= 1'b0;
         i_power_down <= 1'b1;
         i_io_clk_run <= 1'b0;
         pins[0] <= 1'b0;
         cyc(4);
         chk(o_wake, 1'b0);
         repeat (2) begin
            i_wdt_tick <= 1'b1;
            cyc(1);
            i_wdt_tick <= 1'b0;
            cyc(3);
         end
         chk(o_wake, 1'b1);
         pins[0] <= !h[0];
         cyc(4);
         i_startup_done <= 1'b1;
         i_power_down <= 1'b0;
         i_io_clk_run <= 1'b1;
         cyc(4);
         chk(o_irq_req, 32'(h) << 3);
      end
   endtask : t_wake
   // main sequence: reset held six cycles, then every scenario
   initial begin
      cyc(6);
      i_rst_n <= 1'b1;
      cyc(1);
      t_regs();
      t_pc(0);
      t_pc(1);
      i_global_irq_enable <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 4; c++) t_sense(s, 2'(c));
      end
      t_sense(2, 2'b10);
      t_sense(2, 2'b11);
      t_ioclk();
      t_wake();
      tally_and_finish(1'b0);
   end
endmodule : tb_top
bind epi_pin_irq epi_pin_irq_asserts u_chk (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_pin_change_inputs, .i_global_irq_enable,
   .i_vector_ack, .o_irq_req, .o_wake);
